// [cibc_defines.svh]
// Offsets, field positions, codes and reset values for the channel input
// and bias configuration bank.
// Assumes inclusion by bare name from every file that needs the constants.
`ifndef CIBC_DEFINES_SVH
`define CIBC_DEFINES_SVH

// ==========================================================
// Register offsets
`define CIBC_ADDR_BIAS 8'h3B
`define CIBC_ADDR_CH1_IN 8'h3C
`define CIBC_ADDR_FIRST_ANALOG_GAIN 8'h3D

// ==========================================================
// Field positions and widths
`define CIBC_LVL_LSB 4
`define CIBC_LVL_W 3
`define CIBC_FS_LSB 0
`define CIBC_FS_W 2
`define CIBC_KIND_BIT 7
`define CIBC_SRC_LSB 5
`define CIBC_SRC_W 2
`define CIBC_DC_BIT 4
`define CIBC_IMP_LSB 2
`define CIBC_IMP_W 2
`define CIBC_ENH_BIT 0
`define CIBC_GAIN_LSB 2
`define CIBC_GAIN_W 6

// ==========================================================
// Field codes
`define CIBC_LVL_REF 3'h0
`define CIBC_LVL_X1096 3'h1
`define CIBC_LVL_SUPPLY 3'h6
`define CIBC_FS_2P75 2'h0
`define CIBC_FS_2P5 2'h1
`define CIBC_FS_1P375 2'h2
`define CIBC_SRC_DIFF 2'h0
`define CIBC_SRC_SINGLE 2'h1
`define CIBC_SRC_PDM 2'h2
`define CIBC_IMP_2K5 2'h0
`define CIBC_IMP_10K 2'h1
`define CIBC_IMP_20K 2'h2
`define CIBC_GAIN_MAX 6'h2A

// ==========================================================
// Reset values
`define CIBC_FIELD_RST 8'h00
`define CIBC_RDATA_RST 8'h00

`endif

// [cibc_pkg.sv]
// Types shared by the configuration bank and its users.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package cibc_pkg;

   // ==========================================================
   // Register port request
   typedef struct packed {
      logic wr;         // Write strobe, one cycle
      logic rd;         // Read strobe, one cycle
      logic [7:0] addr; // Register offset
      logic [7:0] wdata; // Write data
   } cibc_reg_req_t;

   // ==========================================================
   // Decoded analog front end selects
   typedef struct packed {
      logic bias_ref;          // Bias equals reference
      logic bias_ref_x1096;    // Bias is reference times 1.096
      logic bias_supply;       // Bias is analog supply
      logic bias_rsvd;         // Reserved bias code held
      logic ref_2p75;          // Reference 2.75 V
      logic ref_2p5;           // Reference 2.5 V
      logic ref_1p375;         // Reference 1.375 V
      logic ref_rsvd;          // Reserved reference code held
      logic line_input;        // Line input, else microphone
      logic src_diff;          // Analog differential
      logic src_single;        // Analog single-ended
      logic src_pdm;           // Pulse density microphone
      logic src_rsvd;          // Reserved source code held
      logic dc_couple;         // DC coupling, else AC
      logic imp_2k5;           // 2.5 kohm input
      logic imp_10k;           // 10 kohm input
      logic imp_20k;           // 20 kohm input
      logic imp_rsvd;          // Reserved impedance code held
      logic range_enhancer_on; // Range enhancer running
      logic auto_gain_on;      // Automatic gain running
      logic [5:0] gain_db;     // Analog gain in dB
      logic gain_rsvd;         // Reserved gain code held
   } cibc_afe_sel_t;

endpackage : cibc_pkg

`default_nettype wire

// [cibc_field_reg.sv]
// One writable configuration field with synchronous reset.
// Assumes a single clock and an active low synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module cibc_field_reg #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic wr_en_i,
   input wire logic [W-1:0] wdata_i,
   output logic [W-1:0] field_o
);

   // ==========================================================
   // Elaboration check
   if (W < 1 || W > 8)
   begin : g_bad_w
      $error("field width must be 1 to 8");
   end

   logic [W-1:0] field_ff;  // Stored field
   logic [W-1:0] nxt_field; // Next field

   // Load on write, else hold
   always_comb
   begin
      nxt_field = field_ff;
      if (wr_en_i)
      begin
         nxt_field = wdata_i;
      end
   end

   // Register with reset to the RST code
   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         field_ff <= RST;
      end
      else
      begin
         field_ff <= nxt_field;
      end
   end

   assign field_o = field_ff;

endmodule : cibc_field_reg

`default_nettype wire

// [cibc_bank.sv]
// Bias, full-scale and first channel input configuration register bank.
// Assumes a control port front end that turns serial accesses into
// one-cycle read and write strobes synchronous to ref_clk_i.
//
// Notes on behaviour
// - Bias code 0 ref, 1 x1.096, 6 supply
// - Full-scale code 0 2.75V, 1 2.5V, 2 1.375V
// - Input register bit 7: microphone or line
// - Source code: differential, single-ended, PDM, reserved
// - Input register bit 4: AC or DC
// - Impedance code: 2.5k, 10k, 20k, reserved
// - Bit 0 enables enhancer or gain control
// - Gain bits 7-2 give 0 to 42 dB
`timescale 1ns/1ps
`default_nettype none
`include "cibc_defines.svh"

module cibc_bank #(
   parameter int GAIN_MAX_CODE = 42
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire cibc_pkg::cibc_reg_req_t reg_req_i,
   input wire logic gain_mode_sel_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output cibc_pkg::cibc_afe_sel_t afe_sel_o
);

   // ==========================================================
   // Elaboration check
   if (GAIN_MAX_CODE < 0 || GAIN_MAX_CODE > 63)
   begin : g_bad_gain
      $error("GAIN_MAX_CODE must fit six bits");
   end

   localparam logic [5:0] GAIN_MAX = 6'(GAIN_MAX_CODE); // Highest legal gain

   // ==========================================================
   // Write decode
   logic wr_bias; // Write to bias register
   logic wr_in;   // Write to input register
   logic wr_gain; // Write to gain register

   assign wr_bias = reg_req_i.wr && (reg_req_i.addr == `CIBC_ADDR_BIAS);
   assign wr_in = reg_req_i.wr && (reg_req_i.addr == `CIBC_ADDR_CH1_IN);
   assign wr_gain = reg_req_i.wr && (reg_req_i.addr == `CIBC_ADDR_FIRST_ANALOG_GAIN);

   // ==========================================================
   // Field storage; reserved positions have no storage
   logic [2:0] mic_bias_level;         // Bias level code
   logic [1:0] fullscale_ref_sel;      // Reference code
   logic first_input_kind;             // Line when set
   logic [1:0] first_input_source;     // Source code
   logic first_coupling_sel;           // DC when set
   logic [1:0] first_input_impedance;  // Impedance code
   logic first_range_enhance_en;       // Enhancer or gain enable
   logic [5:0] first_analog_gain;      // Gain code

   cibc_field_reg #(.W(3), .RST(3'(`CIBC_FIELD_RST))) u_lvl (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_bias),
      .wdata_i(reg_req_i.wdata[`CIBC_LVL_LSB +: `CIBC_LVL_W]),
      .field_o(mic_bias_level));
   cibc_field_reg #(.W(2), .RST(2'(`CIBC_FIELD_RST))) u_fs (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_bias),
      .wdata_i(reg_req_i.wdata[`CIBC_FS_LSB +: `CIBC_FS_W]),
      .field_o(fullscale_ref_sel));
   cibc_field_reg #(.W(1), .RST(1'(`CIBC_FIELD_RST))) u_kind (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_in),
      .wdata_i(reg_req_i.wdata[`CIBC_KIND_BIT]),
      .field_o(first_input_kind));
   cibc_field_reg #(.W(2), .RST(2'(`CIBC_FIELD_RST))) u_src (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_in),
      .wdata_i(reg_req_i.wdata[`CIBC_SRC_LSB +: `CIBC_SRC_W]),
      .field_o(first_input_source));
   cibc_field_reg #(.W(1), .RST(1'(`CIBC_FIELD_RST))) u_dc (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_in),
      .wdata_i(reg_req_i.wdata[`CIBC_DC_BIT]),
      .field_o(first_coupling_sel));
   cibc_field_reg #(.W(2), .RST(2'(`CIBC_FIELD_RST))) u_imp (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_in),
      .wdata_i(reg_req_i.wdata[`CIBC_IMP_LSB +: `CIBC_IMP_W]),
      .field_o(first_input_impedance));
   cibc_field_reg #(.W(1), .RST(1'(`CIBC_FIELD_RST))) u_enh (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_in),
      .wdata_i(reg_req_i.wdata[`CIBC_ENH_BIT]),
      .field_o(first_range_enhance_en));
   cibc_field_reg #(.W(6), .RST(6'(`CIBC_FIELD_RST))) u_gain (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_gain),
      .wdata_i(reg_req_i.wdata[`CIBC_GAIN_LSB +: `CIBC_GAIN_W]),
      .field_o(first_analog_gain));

   // ==========================================================
   // Read path
   logic [7:0] rdata_ff;     // Registered read data
   logic [7:0] nxt_rdata;    // Next read data
   logic rvalid_ff;          // Read answer pulse
   logic nxt_rvalid;         // Next answer pulse

   // Assemble read word; reserved bits and unmapped offsets read zero
   always_comb
   begin
      nxt_rdata = rdata_ff;
      nxt_rvalid = reg_req_i.rd;
      if (reg_req_i.rd)
      begin
         nxt_rdata = `CIBC_RDATA_RST;
         unique case (reg_req_i.addr)
            `CIBC_ADDR_BIAS:
            begin
               nxt_rdata[`CIBC_LVL_LSB +: `CIBC_LVL_W] = mic_bias_level;
               nxt_rdata[`CIBC_FS_LSB +: `CIBC_FS_W] = fullscale_ref_sel;
            end
            `CIBC_ADDR_CH1_IN:
            begin
               nxt_rdata[`CIBC_KIND_BIT] = first_input_kind;
               nxt_rdata[`CIBC_SRC_LSB +: `CIBC_SRC_W] = first_input_source;
               nxt_rdata[`CIBC_DC_BIT] = first_coupling_sel;
               nxt_rdata[`CIBC_IMP_LSB +: `CIBC_IMP_W] = first_input_impedance;
               nxt_rdata[`CIBC_ENH_BIT] = first_range_enhance_en;
            end
            `CIBC_ADDR_FIRST_ANALOG_GAIN:
            begin
               nxt_rdata[`CIBC_GAIN_LSB +: `CIBC_GAIN_W] = first_analog_gain;
            end
            default:
            begin
               // Unmapped offset answers zero
               nxt_rdata = `CIBC_RDATA_RST;
            end
         endcase
      end
   end

   // Register read answer
   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         rdata_ff <= `CIBC_RDATA_RST;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign reg_rvalid_o = rvalid_ff;

   // ==========================================================
   // Front end decode
   cibc_pkg::cibc_afe_sel_t sel_ff;  // Registered selects
   cibc_pkg::cibc_afe_sel_t nxt_sel; // Next selects

   // Turn field codes into one-hot selects
   always_comb
   begin
      nxt_sel = '0;
      nxt_sel.bias_ref = (mic_bias_level == `CIBC_LVL_REF);
      nxt_sel.bias_ref_x1096 = (mic_bias_level == `CIBC_LVL_X1096);
      nxt_sel.bias_supply = (mic_bias_level == `CIBC_LVL_SUPPLY);
      nxt_sel.bias_rsvd = !(nxt_sel.bias_ref || nxt_sel.bias_ref_x1096
                            || nxt_sel.bias_supply);
      nxt_sel.ref_2p75 = (fullscale_ref_sel == `CIBC_FS_2P75);
      nxt_sel.ref_2p5 = (fullscale_ref_sel == `CIBC_FS_2P5);
      nxt_sel.ref_1p375 = (fullscale_ref_sel == `CIBC_FS_1P375);
      nxt_sel.ref_rsvd = (fullscale_ref_sel == 2'h3);
      nxt_sel.line_input = first_input_kind;
      nxt_sel.src_diff = (first_input_source == `CIBC_SRC_DIFF);
      nxt_sel.src_single = (first_input_source == `CIBC_SRC_SINGLE);
      nxt_sel.src_pdm = (first_input_source == `CIBC_SRC_PDM);
      nxt_sel.src_rsvd = (first_input_source == 2'h3);
      nxt_sel.dc_couple = first_coupling_sel;
      nxt_sel.imp_2k5 = (first_input_impedance == `CIBC_IMP_2K5);
      nxt_sel.imp_10k = (first_input_impedance == `CIBC_IMP_10K);
      nxt_sel.imp_20k = (first_input_impedance == `CIBC_IMP_20K);
      nxt_sel.imp_rsvd = (first_input_impedance == 2'h3);
      // Mode bit low picks enhancer, high picks gain control
      nxt_sel.range_enhancer_on = first_range_enhance_en && !gain_mode_sel_i;
      nxt_sel.auto_gain_on = first_range_enhance_en && gain_mode_sel_i;
      nxt_sel.gain_db = first_analog_gain;
      nxt_sel.gain_rsvd = (first_analog_gain > GAIN_MAX);
   end

   // Register selects so outputs come from flip-flops
   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         sel_ff <= '0;
      end
      else
      begin
         sel_ff <= nxt_sel;
      end
   end

   assign afe_sel_o = sel_ff;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   AST_BIAS_SUPPLY: assert property (
      wr_bias && reg_req_i.wdata[6:4] == 3'h6 |-> ##2 afe_sel_o.bias_supply
                                                    && !afe_sel_o.bias_ref)
      else $error("bias supply code not decoded");
   AST_BIAS_RSVD: assert property (
      wr_bias && reg_req_i.wdata[6:4] == 3'h3 |-> ##2 afe_sel_o.bias_rsvd)
      else $error("reserved bias code not flagged");
   AST_FS_1P375: assert property (
      wr_bias && reg_req_i.wdata[1:0] == 2'h2 |-> ##2 afe_sel_o.ref_1p375
                                                    && !afe_sel_o.ref_2p75)
      else $error("1.375 V reference not decoded");
   AST_KIND: assert property (
      wr_in |-> ##2 afe_sel_o.line_input == $past(reg_req_i.wdata[7], 2))
      else $error("input kind does not follow bit 7");
   AST_SRC_PDM: assert property (
      wr_in && reg_req_i.wdata[6:5] == 2'h2 |-> ##2 afe_sel_o.src_pdm
                                                  && !afe_sel_o.src_diff)
      else $error("PDM source not decoded");
   AST_DC: assert property (
      wr_in |-> ##2 afe_sel_o.dc_couple == $past(reg_req_i.wdata[4], 2))
      else $error("coupling does not follow bit 4");
   AST_IMP_20K: assert property (
      wr_in && reg_req_i.wdata[3:2] == 2'h2 |-> ##2 afe_sel_o.imp_20k)
      else $error("20 kohm impedance not decoded");
   AST_ENH_OFF: assert property (
      wr_in && !reg_req_i.wdata[0] |-> ##2 !afe_sel_o.range_enhancer_on
                                         && !afe_sel_o.auto_gain_on)
      else $error("enhancer or gain control on while disabled");
   AST_GAIN: assert property (
      wr_gain |-> ##2 afe_sel_o.gain_db == $past(reg_req_i.wdata[7:2], 2)
         && afe_sel_o.gain_rsvd == ($past(reg_req_i.wdata[7:2], 2) > GAIN_MAX))
      else $error("gain code or reserved flag wrong");
   AST_RSVD_ZERO: assert property (
      reg_req_i.rd && reg_req_i.addr == 8'h3C |=> reg_rvalid_o
                                                 && reg_rdata_o[1] == 1'b0)
      else $error("reserved input bit read nonzero");
   AST_GAIN_LOW_ZERO: assert property (
      reg_req_i.rd && reg_req_i.addr == 8'h3D |=> reg_rdata_o[1:0] == 2'h0)
      else $error("reserved gain bits read nonzero");

   COV_PDM: cover property (wr_in ##2 afe_sel_o.src_pdm);
   COV_AUTO_GAIN: cover property (afe_sel_o.auto_gain_on);
   COV_GAIN_MAX: cover property (wr_gain ##2 afe_sel_o.gain_db == 6'h2A);
   COV_READ_BIAS: cover property (reg_req_i.rd && reg_req_i.addr == 8'h3B);

endmodule : cibc_bank

`default_nettype wire

// [cibc_host_model.sv]
// Host model that issues register writes and reads on the control strobes.
// Assumes callers enter each task 1 ns after a rising edge of ref_clk_i.
`timescale 1ns/1ps
`default_nettype none

module cibc_host_model (
   input wire logic ref_clk_i,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i,
   output cibc_pkg::cibc_reg_req_t req_o
);
   // ==========================================
   // Idle request, address and data parked
   initial req_o = '{wr: 1'b0, rd: 1'b0, addr: 8'hA5, wdata: 8'h5A};

   // Drop strobes; released lines show the inverse of their last value
   task automatic release_req();
   begin
      req_o.wr = 1'b0;
      req_o.rd = 1'b0;
      req_o.addr = ~req_o.addr;
      req_o.wdata = ~req_o.wdata;
   end
   endtask : release_req

   // Write, then one idle cycle so the decoded selects settle
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
   begin
      req_o.addr = addr;
      req_o.wdata = data;
      req_o.wr = 1'b1;
      @(posedge ref_clk_i);
      #1;
      release_req();
      @(posedge ref_clk_i);
      #1;
   end
   endtask : write_reg

   // Read with a bounded wait for the answer strobe
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      int n;
   begin
      req_o.addr = addr;
      req_o.rd = 1'b1;
      @(posedge ref_clk_i);
      #1;
      release_req();
      ok = 1'b0;
      data = 8'h00;
      n = 0;
      while (n < 4 && ok !== 1'b1)
      begin
         if (rvalid_i === 1'b1)
         begin
            ok = 1'b1;
            data = rdata_i;
         end
         else
         begin
            @(posedge ref_clk_i);
            #1;
            n++;
         end
      end
      @(posedge ref_clk_i);
      #1;
   end
   endtask : read_reg

endmodule : cibc_host_model

`default_nettype wire

// [testbench.sv]
// Self-checking bench for the channel input and bias configuration bank.
// Assumes the host model above drives the register strobes.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic ref_clk_i = 1'b0; // 20 MHz clock
   logic reset_n_i = 1'b0; // Synchronous reset, active low
   logic gain_mode_sel_i = 1'b0; // Enhancer or gain control pick
   cibc_pkg::cibc_reg_req_t req; // Host requests
   logic [7:0] rdata; // Read answer
   logic rvalid; // Read answer strobe
   cibc_pkg::cibc_afe_sel_t afe; // Decoded selects
   int err_count = 0; // Mismatches
   int check_count = 0; // Comparisons

   // ==========================================
   // Clock, design and host
   always #25 ref_clk_i = ~ref_clk_i;

   cibc_bank #(.GAIN_MAX_CODE(42)) dut (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .reg_req_i(req),
      .gain_mode_sel_i(gain_mode_sel_i),
      .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid),
      .afe_sel_o(afe)
   );

   cibc_host_model host (
      .ref_clk_i(ref_clk_i),
      .rdata_i(rdata),
      .rvalid_i(rvalid),
      .req_o(req)
   );

   // ==========================================
   // Shared checks
   task automatic summarize();
   begin
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask : summarize

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
   begin
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask : chk

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
   begin
      host.read_reg(a, d, ok);
      if (ok !== 1'b1)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t no read answer at %h got=%h exp=%h", $time, a, ok, 1'b1);
         summarize();
      end
      else
      begin
         chk(d, exp);
      end
   end
   endtask : rd_chk

   // One-hot group packers
   function automatic logic [7:0] bias_g();
      return {4'h0, afe.bias_ref, afe.bias_ref_x1096, afe.bias_supply, afe.bias_rsvd};
   endfunction : bias_g
   function automatic logic [7:0] ref_g();
      return {4'h0, afe.ref_2p75, afe.ref_2p5, afe.ref_1p375, afe.ref_rsvd};
   endfunction : ref_g
   function automatic logic [7:0] src_g();
      return {4'h0, afe.src_diff, afe.src_single, afe.src_pdm, afe.src_rsvd};
   endfunction : src_g
   function automatic logic [7:0] imp_g();
      return {4'h0, afe.imp_2k5, afe.imp_10k, afe.imp_20k, afe.imp_rsvd};
   endfunction : imp_g

   // ==========================================
   // Scenarios
   // Reset values of all registers and of all selects but gain_rsvd
   task automatic test_reset();
   begin
      rd_chk(8'h3B, 8'h00);
      rd_chk(8'h3C, 8'h00);
      rd_chk(8'h3D, 8'h00);
      chk(bias_g(), 8'h08);
      chk(ref_g(), 8'h08);
      chk(src_g(), 8'h08);
      chk(imp_g(), 8'h08);
      chk({4'h0, afe.line_input, afe.dc_couple, afe.range_enhancer_on, afe.auto_gain_on},
         8'h00);
      chk({2'h0, afe.gain_db}, 8'h00);
   end
   endtask : test_reset

   // Every bias level and full-scale code, reserved bits set on write
   task automatic test_bias();
      logic [2:0] lv;
      logic [1:0] fs;
   begin
      for (int i = 0; i < 8; i++)
      begin
         lv = i[2:0];
         fs = i[1:0];
         host.write_reg(8'h3B, {1'b1, lv, 2'h3, fs});
         chk(bias_g(), lv == 3'h0 ? 8'h08 : lv == 3'h1 ? 8'h04 : lv == 3'h6 ? 8'h02 : 8'h01);
         chk(ref_g(), 8'h08 >> fs);
         rd_chk(8'h3B, {1'b0, lv, 2'h0, fs});
      end
   end
   endtask : test_bias

   // Kind, source, coupling, impedance and enable combinations
   task automatic test_input();
      logic [1:0] c;
      logic [7:0] d;
   begin
      for (int i = 0; i < 4; i++)
      begin
         c = i[1:0];
         d = {c[0], c, ~c[0], c, 1'b1, c[1]};
         host.write_reg(8'h3C, d);
         chk({6'h0, afe.line_input, afe.dc_couple}, {6'h0, c[0], ~c[0]});
         chk(src_g(), 8'h08 >> c);
         chk(imp_g(), 8'h08 >> c);
         chk({6'h0, afe.range_enhancer_on, afe.auto_gain_on}, c[1] ? 8'h02 : 8'h00);
         rd_chk(8'h3C, d & 8'hFD);
      end
   end
   endtask : test_input

   // Enable routed to enhancer or gain control, one cycle after the mode input
   task automatic test_mode();
   begin
      host.write_reg(8'h3C, 8'h01);
      chk({6'h0, afe.range_enhancer_on, afe.auto_gain_on}, 8'h02);
      gain_mode_sel_i = 1'b1;
      @(posedge ref_clk_i);
      #1;
      chk({6'h0, afe.range_enhancer_on, afe.auto_gain_on}, 8'h01);
      gain_mode_sel_i = 1'b0;
      @(posedge ref_clk_i);
      #1;
      chk({6'h0, afe.range_enhancer_on, afe.auto_gain_on}, 8'h02);
   end
   endtask : test_mode

   // Gain codes at both ends of the legal range and beyond
   task automatic test_gain();
      logic [5:0] codes [5] = '{6'h00, 6'h01, 6'h2A, 6'h2B, 6'h3F};
   begin
      foreach (codes[k])
      begin
         host.write_reg(8'h3D, {codes[k], 2'h3});
         chk({7'h0, afe.gain_rsvd}, {7'h0, codes[k] > 6'h2A});
         chk({2'h0, afe.gain_db}, {2'h0, codes[k]});
         rd_chk(8'h3D, {codes[k], 2'h0});
      end
   end
   endtask : test_gain

   // Unmapped places read zero; reset in mid-run clears fields
   task automatic test_unmapped_reset();
   begin
      host.write_reg(8'h3A, 8'hFF);
      rd_chk(8'h3A, 8'h00);
      rd_chk(8'h3E, 8'h00);
      rd_chk(8'h3D, 8'hFC);
      reset_n_i = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      #1;
      reset_n_i = 1'b1;
      test_reset();
   end
   endtask : test_unmapped_reset

   // ==========================================
   // Main sequence
   initial
   begin
      repeat (3) @(posedge ref_clk_i);
      #1;
      reset_n_i = 1'b1;
      @(posedge ref_clk_i);
      #1;
      test_reset();
      test_bias();
      test_input();
      test_mode();
      test_gain();
      test_unmapped_reset();
      summarize();
   end

endmodule : testbench

`default_nettype wire
